// ===== irrx_consts.svh
// constants of the infrared pulse-position receiver: register indices, fields, resets
// assumes a 20-bit APB byte address; each register index sits at byte address index*4
//
// What this block does
// [R1] direction bit picks LSB-first or MSB-first shifting
// [R2] six 5-bit thresholds, bit 4 in high-bits register
// [R3] format A guide measured rising to falling
// [R4] guide accepted within low+1 to below high+1
// [R5] format A data measured falling to falling
// [R6] data window decides zero or one
// [R7] software orders thresholds low below high
// [R8] end when count reaches data1 high plus one
// [R9] software keeps criteria and gaps eight units
// [R10] accepted guide sets flag, clears shift state
// [R11] good bit shifts; every eighth bit copies byte out
// [R12] bad data pulse flags error, back to idle
// [R13] three-bit counter counts received data bits
// [R14] end sets flags, holds; shift read resumes
// [R15] format B measures everything rising to rising
// [R16] format B otherwise behaves as format A
// [R17] format C first rising edge clears shift state
// [R18] format C data measured rising to rising
// [R19] format C idle waits for next rising edge
// [R20] count select gives multipliers 4, 8, 16, 32; formats D and E get 2, 4, 8, 16
// [R21] hold ignores input; stopping run clears hold
// [R22] guide start codes 0,1,4; edge start 2,3
// [R23] mismatch counter ticks, restarts each reference edge
`ifndef IRRX_CONSTS_SVH
`define IRRX_CONSTS_SVH

// register indices (byte address is index times four)
`define IRRX_IDX_SFT      18'h0FE29
`define IRRX_IDX_RDT      18'h0FE2A
`define IRRX_IDX_CTPR     18'h0FE2B
`define IRRX_IDX_GPW      18'h0FE2C
`define IRRX_IDX_DT0W     18'h0FE2D
`define IRRX_IDX_DT1W     18'h0FE2E
`define IRRX_IDX_XHW      18'h0FE2F
`define IRRX_IDX_CTRL     18'h0FE30
`define IRRX_IDX_STAT     18'h0FE31

// reset values
`define IRRX_RST_BYTE     8'h00
`define IRRX_RST_BCT      3'h0
`define IRRX_RST_SEL      4'h0
`define IRRX_RST_CNT      6'h00
`define IRRX_XHW_RSVD_RD  8'h40

// control register fields
`define IRRX_CTRL_RUN     0
`define IRRX_CTRL_FMT_LO  1
`define IRRX_CTRL_FMT_HI  3
`define IRRX_CTRL_PS_LO   4
`define IRRX_CTRL_PS_HI   6
// status register fields (write one to clear)
`define IRRX_ST_GPOK      0
`define IRRX_ST_FULL      1
`define IRRX_ST_DERR      2
`define IRRX_ST_REND      3
// high-bits register fields
`define IRRX_XHW_DIR      7
`define IRRX_XHW_D1H      5
`define IRRX_XHW_D1L      4
`define IRRX_XHW_D0H      3
`define IRRX_XHW_D0L      2
`define IRRX_XHW_GH       1
`define IRRX_XHW_GL       0
`define IRRX_XHW_MASK     8'hBF

// receive format codes
`define IRRX_FMT_A        3'h0
`define IRRX_FMT_B        3'h1
`define IRRX_FMT_C        3'h2
`define IRRX_FMT_D        3'h3
`define IRRX_FMT_E        3'h4

// counting constants
`define IRRX_CNT_ONE      6'h01
`define IRRX_CNT_MAX      6'h3F
`define IRRX_BCT_LAST     3'h7
`define IRRX_MULT_BASE    6'h04
`define IRRX_BASE_ONE     8'h01

`endif

// ===== irrx_pkg.sv
// types shared by the receiver core and its unit tick generator
// assumes irrx_consts.svh supplies the numeric constants
`default_nettype none
package irrx_pkg;
    // one-hot receiver states
    typedef enum logic [3:0]
    {
        IRRX_IDLE  = 4'b0001,
        IRRX_GUIDE = 4'b0010,
        IRRX_DATA  = 4'b0100,
        IRRX_HOLD  = 4'b1000
    } irrx_state_e;
    typedef logic [31:0] irrx_word_t;   // apb data word
    typedef logic [5:0]  irrx_cnt_t;    // mismatch count
    typedef logic [4:0]  irrx_thr_t;    // 5-bit threshold
endpackage
`default_nettype wire

// ===== irrx_tick_if.sv
// link between the receiver core and its unit tick generator
// assumes both ends run on the core clock
`timescale 1ns/100ps
`default_nettype none
interface irrx_tick_if;
    logic [2:0] period_sel;   // prescaler period select
    logic [1:0] count_sel;    // guide or data count select
    logic       half_mult;    // halved multiplier table
    logic       restart;      // realign at reference edge
    logic       unit_tick;    // one pulse per unit
    modport core (output period_sel, output count_sel, output half_mult,
                  output restart, input unit_tick);
    modport gen  (input period_sel, input count_sel, input half_mult,
                  input restart, output unit_tick);
endinterface
`default_nettype wire

// ===== irrx_tick_gen.sv
// unit tick generator: prescaler period times count select multiplier
// assumes restart is a one-cycle pulse from the core
`timescale 1ns/100ps
`default_nettype none
`include "irrx_consts.svh"
module irrx_tick_gen (
    input  wire logic       i_core_clk,   // core clock
    input  wire logic       i_sys_rst,    // async reset, high
    irrx_tick_if.gen        tick          // core link
);
    import irrx_pkg::*;

    logic [7:0] base_cnt_reg;   // prescaler period counter
    logic [5:0] mult_cnt_reg;   // multiplier counter
    logic       tick_reg;       // registered unit tick
    logic [7:0] base_last;      // last prescaler count
    logic [5:0] mult_last;      // last multiplier count
    logic       base_done;      // period complete
    logic       mult_done;      // unit complete

    // prescaler period is 2^sel core clocks
    assign base_last = 8'((`IRRX_BASE_ONE << tick.period_sel) - `IRRX_BASE_ONE);
    // multiplier 4/8/16/32, halved for the last two formats
    assign mult_last = 6'(((`IRRX_MULT_BASE << tick.count_sel) >> tick.half_mult)
                          - `IRRX_CNT_ONE);   // [R20]
    assign base_done = (base_cnt_reg == base_last);
    assign mult_done = (mult_cnt_reg == mult_last);
    assign tick.unit_tick = tick_reg;

    // counters, restarted at every reference edge
    always_ff @(posedge i_core_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            base_cnt_reg <= `IRRX_RST_BYTE;
            mult_cnt_reg <= `IRRX_RST_CNT;
            tick_reg     <= 1'b0;
        end
        else if (tick.restart)
        begin
            base_cnt_reg <= `IRRX_RST_BYTE;
            mult_cnt_reg <= `IRRX_RST_CNT;
            tick_reg     <= 1'b0;
        end
        else
        begin
            base_cnt_reg <= base_done ? `IRRX_RST_BYTE : 8'(base_cnt_reg + `IRRX_BASE_ONE);
            if (base_done)
            begin
                mult_cnt_reg <= mult_done ? `IRRX_RST_CNT : 6'(mult_cnt_reg + `IRRX_CNT_ONE);
            end
            tick_reg <= base_done & mult_done;
        end
    end

    // unit tick never fires right after a restart
    a_tick_after_restart: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        tick.restart |=> !tick.unit_tick)   // [R23]
        else $error("unit tick right after restart");
endmodule // irrx_tick_gen
`default_nettype wire

// ===== irrx_receiver.sv
// infrared pulse-position receiver core with its apb register file
// assumes a zero-wait apb master and an asynchronous demodulated input pin
`timescale 1ns/100ps
`default_nettype none
`include "irrx_consts.svh"
module irrx_receiver (
    input  wire logic              i_core_clk,   // 250 MHz core clock
    input  wire logic              i_sys_rst,    // async reset, high
    input  wire logic              i_ir_rx,      // demodulated remote input
    input  wire logic              i_psel,       // apb select
    input  wire logic              i_penable,    // apb enable
    input  wire logic              i_pwrite,     // apb direction
    input  wire logic [19:0]       i_paddr,      // apb byte address
    input  wire irrx_pkg::irrx_word_t i_pwdata,  // apb write data
    output var   irrx_pkg::irrx_word_t o_prdata, // apb read data
    output logic                   o_pready,     // apb ready
    output logic                   o_pslverr     // apb error
);
    import irrx_pkg::*;

    irrx_tick_if tick_if ();   // core to tick generator

    // software registers
    logic [7:0]  ctrl_reg;     // run, format, period select
    logic [7:0]  gpw_reg;      // guide_width_register
    logic [7:0]  dt0w_reg;     // data0_width_register
    logic [7:0]  dt1w_reg;     // data1_width_register
    logic [7:0]  xhw_reg;      // width_high_bits_and_shift_direction
    logic [3:0]  csel_reg;     // guide and data count selects
    // receiver state
    logic [7:0]  sft_reg;      // receive_shift_register
    logic [7:0]  rdt_reg;      // receive_data_register
    logic [2:0]  bct_reg;      // received_bit_counter
    logic        hold_reg;     // hold_flag
    logic        gpok_reg;     // guide_accepted_flag
    logic        full_reg;     // data_full_flag
    logic        derr_reg;     // data_error_flag
    logic        rend_reg;     // reception_end_flag
    irrx_state_e state_reg;    // receiver state
    irrx_state_e state_next;   // next receiver state
    irrx_cnt_t   mm_cnt_reg;   // mismatch_counter
    irrx_cnt_t   mm_cnt_next;  // next mismatch count
    logic [7:0]  prdata_reg;   // read data latch
    // input synchroniser and filtered level
    logic        sync1_reg;    // first stage
    logic        sync2_reg;    // second stage
    logic        sync3_reg;    // third stage
    logic        lvl_reg;      // accepted input level
    logic        lvl_next;     // next accepted level

    // apb byte-address to register match
    function automatic logic idx_hit(input logic [19:0] addr, input logic [17:0] idx);
        idx_hit = (addr[19:2] == idx);
    endfunction

    // inclusive-low, exclusive-high width window
    function automatic logic in_win(input irrx_cnt_t cnt, input irrx_thr_t lo,
                                    input irrx_thr_t hi);
        in_win = (cnt >= 6'({1'b0, lo} + `IRRX_CNT_ONE)) &&
                 (cnt <  6'({1'b0, hi} + `IRRX_CNT_ONE));
    endfunction

    // apb phase decode
    wire         apb_setup = i_psel & ~i_penable;
    wire         apb_acc   = i_psel & i_penable;
    wire         apb_wr    = apb_acc & i_pwrite;
    wire         apb_rd    = apb_acc & ~i_pwrite;
    wire         hit_sft   = idx_hit(i_paddr, `IRRX_IDX_SFT);
    wire         hit_rdt   = idx_hit(i_paddr, `IRRX_IDX_RDT);
    wire         hit_ctpr  = idx_hit(i_paddr, `IRRX_IDX_CTPR);
    wire         hit_gpw   = idx_hit(i_paddr, `IRRX_IDX_GPW);
    wire         hit_dt0w  = idx_hit(i_paddr, `IRRX_IDX_DT0W);
    wire         hit_dt1w  = idx_hit(i_paddr, `IRRX_IDX_DT1W);
    wire         hit_xhw   = idx_hit(i_paddr, `IRRX_IDX_XHW);
    wire         hit_ctrl  = idx_hit(i_paddr, `IRRX_IDX_CTRL);
    wire         hit_stat  = idx_hit(i_paddr, `IRRX_IDX_STAT);
    wire         addr_ok   = hit_sft | hit_rdt | hit_ctpr | hit_gpw | hit_dt0w |
                             hit_dt1w | hit_xhw | hit_ctrl | hit_stat;
    wire         rd_sft    = apb_rd & hit_sft;
    wire         wr_stat   = apb_wr & hit_stat;

    // control fields
    wire         run       = ctrl_reg[`IRRX_CTRL_RUN];
    wire [2:0]   fmt       = ctrl_reg[`IRRX_CTRL_FMT_HI:`IRRX_CTRL_FMT_LO];
    wire         dir_msb   = xhw_reg[`IRRX_XHW_DIR];
    // guide-started formats versus edge-started formats
    wire         guide_fmt = (fmt == `IRRX_FMT_A) | (fmt == `IRRX_FMT_B) |
                             (fmt == `IRRX_FMT_E);   // [R22]
    // only format A references the falling edge
    wire         fall_ref  = (fmt == `IRRX_FMT_A);   // [R3] [R5] [R15] [R18]

    // 5-bit thresholds, top bit from the high-bits register
    wire irrx_thr_t gl  = {xhw_reg[`IRRX_XHW_GL],  gpw_reg[3:0]};    // [R2]
    wire irrx_thr_t gh  = {xhw_reg[`IRRX_XHW_GH],  gpw_reg[7:4]};    // [R2]
    wire irrx_thr_t d0l = {xhw_reg[`IRRX_XHW_D0L], dt0w_reg[3:0]};   // [R2]
    wire irrx_thr_t d0h = {xhw_reg[`IRRX_XHW_D0H], dt0w_reg[7:4]};   // [R2]
    wire irrx_thr_t d1l = {xhw_reg[`IRRX_XHW_D1L], dt1w_reg[3:0]};   // [R2]
    wire irrx_thr_t d1h = {xhw_reg[`IRRX_XHW_D1H], dt1w_reg[7:4]};   // [R2]

    // edges of the accepted input level
    wire         rise      = lvl_next & ~lvl_reg;
    wire         fall      = ~lvl_next & lvl_reg;
    wire         ref_edge  = fall_ref ? fall : rise;   // [R16]

    // window classification of the running width
    wire         guide_ok  = in_win(mm_cnt_reg, gl, gh);     // [R4]
    wire         bit0_ok   = in_win(mm_cnt_reg, d0l, d0h);   // [R6]
    wire         bit1_ok   = in_win(mm_cnt_reg, d1l, d1h);   // [R6]
    wire         end_cond  = (mm_cnt_reg >= 6'({1'b0, d1h} + `IRRX_CNT_ONE));   // [R8]

    // receiver events
    wire         in_idle   = (state_reg == IRRX_IDLE);
    wire         in_guide  = (state_reg == IRRX_GUIDE);
    wire         in_data   = (state_reg == IRRX_DATA);
    wire         in_hold   = (state_reg == IRRX_HOLD);
    wire         idle_rise = run & in_idle & rise;
    wire         g_start   = idle_rise & guide_fmt;
    wire         c_start   = idle_rise & ~guide_fmt;   // [R17] [R19]
    wire         guide_end = run & in_guide & ref_edge;
    wire         guide_acc = guide_end & guide_ok;     // [R10]
    wire         data_edge = run & in_data & ref_edge;
    wire         take_bit  = data_edge & (bit0_ok | bit1_ok);   // [R11]
    wire         bad_bit   = data_edge & ~(bit0_ok | bit1_ok);  // [R12]
    wire         timeout   = run & in_data & ~ref_edge & end_cond;   // [R8] [R14]
    wire         rx_bit    = bit1_ok;
    wire         clr_shift = guide_acc | c_start;   // [R10] [R17]
    wire         byte_done = take_bit & (bct_reg == `IRRX_BCT_LAST);   // [R11]
    wire         restart   = g_start | c_start | guide_end | data_edge;  // [R23]
    // bit shifted in by the selected direction
    wire [7:0]   shifted   = dir_msb ? {sft_reg[6:0], rx_bit}
                                     : {rx_bit, sft_reg[7:1]};   // [R1]

    // tick generator steering: data select while measuring data
    assign tick_if.period_sel = ctrl_reg[`IRRX_CTRL_PS_HI:`IRRX_CTRL_PS_LO];
    assign tick_if.count_sel  = in_data ? csel_reg[1:0] : csel_reg[3:2];   // [R3] [R5]
    assign tick_if.half_mult  = (fmt == `IRRX_FMT_D) | (fmt == `IRRX_FMT_E);
    assign tick_if.restart    = restart | ~run;

    irrx_tick_gen u_tick (
        .i_core_clk (i_core_clk),
        .i_sys_rst  (i_sys_rst),
        .tick       (tick_if.gen)
    );

    // read data selection
    wire [7:0]   rd_mux = hit_sft  ? sft_reg :
                          hit_rdt  ? rdt_reg :
                          hit_ctpr ? {csel_reg, hold_reg, bct_reg} :
                          hit_gpw  ? gpw_reg :
                          hit_dt0w ? dt0w_reg :
                          hit_dt1w ? dt1w_reg :
                          hit_xhw  ? (xhw_reg | `IRRX_XHW_RSVD_RD) :
                          hit_ctrl ? ctrl_reg :
                          hit_stat ? {4'h0, rend_reg, derr_reg, full_reg, gpok_reg} :
                                     `IRRX_RST_BYTE;

    assign o_prdata  = {24'h000000, prdata_reg};
    assign o_pready  = 1'b1;
    assign o_pslverr = apb_acc & ~addr_ok;

    // accepted level follows once stages two and three agree
    assign lvl_next = (sync2_reg == sync3_reg) ? sync3_reg : lvl_reg;

    // mismatch count: restart at reference edges, saturate at top
    assign mm_cnt_next = (restart | ~run) ? `IRRX_RST_CNT :
                         (tick_if.unit_tick & (mm_cnt_reg != `IRRX_CNT_MAX)) ?
                         6'(mm_cnt_reg + `IRRX_CNT_ONE) : mm_cnt_reg;   // [R23]

    // receiver state transitions
    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            IRRX_IDLE:
            begin
                if (g_start)
                    state_next = IRRX_GUIDE;       // guide measurement
                else if (c_start)
                    state_next = IRRX_DATA;        // [R17] [R22]
            end
            IRRX_GUIDE:
            begin
                if (guide_end)
                    state_next = guide_ok ? IRRX_DATA : IRRX_IDLE;   // [R4] [R10]
            end
            IRRX_DATA:
            begin
                if (bad_bit)
                    state_next = IRRX_IDLE;        // [R12] [R19]
                else if (timeout)
                    state_next = IRRX_HOLD;        // [R14]
            end
            IRRX_HOLD:
            begin
                if (rd_sft)
                    state_next = IRRX_IDLE;        // [R14] [R21]
            end
            default:
                state_next = IRRX_IDLE;            // illegal code recovery
        endcase
        if (!run)
            state_next = IRRX_IDLE;                // [R21]
    end

    // input synchroniser, three stages
    always_ff @(posedge i_core_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
            sync3_reg <= 1'b0;
            lvl_reg   <= 1'b0;
        end
        else
        begin
            sync1_reg <= i_ir_rx;
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
            lvl_reg   <= lvl_next;
        end
    end

    // software-written registers and read latch
    always_ff @(posedge i_core_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            ctrl_reg   <= `IRRX_RST_BYTE;
            gpw_reg    <= `IRRX_RST_BYTE;
            dt0w_reg   <= `IRRX_RST_BYTE;
            dt1w_reg   <= `IRRX_RST_BYTE;
            xhw_reg    <= `IRRX_RST_BYTE;
            csel_reg   <= `IRRX_RST_SEL;
            prdata_reg <= `IRRX_RST_BYTE;
        end
        else
        begin
            if (apb_wr & hit_ctrl) ctrl_reg <= i_pwdata[7:0];
            if (apb_wr & hit_gpw)  gpw_reg  <= i_pwdata[7:0];
            if (apb_wr & hit_dt0w) dt0w_reg <= i_pwdata[7:0];
            if (apb_wr & hit_dt1w) dt1w_reg <= i_pwdata[7:0];
            if (apb_wr & hit_xhw)  xhw_reg  <= i_pwdata[7:0] & `IRRX_XHW_MASK;
            if (apb_wr & hit_ctpr) csel_reg <= i_pwdata[7:4];
            if (apb_setup)         prdata_reg <= rd_mux;
        end
    end

    // receiver datapath
    always_ff @(posedge i_core_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            state_reg  <= IRRX_IDLE;
            mm_cnt_reg <= `IRRX_RST_CNT;
            sft_reg    <= `IRRX_RST_BYTE;
            rdt_reg    <= `IRRX_RST_BYTE;
            bct_reg    <= `IRRX_RST_BCT;
            hold_reg   <= 1'b0;
        end
        else
        begin
            state_reg  <= state_next;
            mm_cnt_reg <= mm_cnt_next;
            if (!run | clr_shift | byte_done)
                sft_reg <= `IRRX_RST_BYTE;                  // [R10] [R11] [R17]
            else if (take_bit)
                sft_reg <= shifted;                         // [R1] [R11]
            if (!run | clr_shift)
                bct_reg <= `IRRX_RST_BCT;                   // [R13]
            else if (take_bit)
                bct_reg <= 3'(bct_reg + 3'h1);              // [R13]
            if (byte_done)
                rdt_reg <= shifted;                         // [R11]
            if (!run)
                hold_reg <= 1'b0;                           // [R21]
            else if (timeout)
                hold_reg <= 1'b1;                           // [R14]
            else if (rd_sft)
                hold_reg <= 1'b0;                           // [R14]
        end
    end

    // sticky flags: hardware set wins over software clear
    always_ff @(posedge i_core_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            gpok_reg <= 1'b0;
            full_reg <= 1'b0;
            derr_reg <= 1'b0;
            rend_reg <= 1'b0;
        end
        else
        begin
            gpok_reg <= guide_acc | (gpok_reg & ~(wr_stat & i_pwdata[`IRRX_ST_GPOK])); // [R10]
            full_reg <= byte_done | (full_reg & ~(wr_stat & i_pwdata[`IRRX_ST_FULL])); // [R11]
            derr_reg <= bad_bit   | (derr_reg & ~(wr_stat & i_pwdata[`IRRX_ST_DERR])); // [R12]
            rend_reg <= timeout   | (rend_reg & ~(wr_stat & i_pwdata[`IRRX_ST_REND])); // [R14]
        end
    end

    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_sys_rst);

    sequence s_data_edge;
        in_data && ref_edge && run;
    endsequence
    sequence s_hold_wait;
        in_hold && run && !rd_sft;
    endsequence

    a_guide_accept: assert property (guide_acc |=> gpok_reg && bct_reg == 3'h0 // [R10]
        && sft_reg == 8'h00 && state_reg == IRRX_DATA)
        else $error("guide acceptance did not clear and flag");
    a_data_error: assert property (s_data_edge ##0 (!bit0_ok && !bit1_ok) // [R12]
        |=> derr_reg && state_reg == IRRX_IDLE)
        else $error("bad pulse did not raise error");
    a_end_hold: assert property (timeout |=> hold_reg && rend_reg // [R14]
        && state_reg == IRRX_HOLD)
        else $error("end of reception not held");
    a_hold_frozen: assert property (s_hold_wait |=> $stable(sft_reg) // [R21]
        && $stable(bct_reg) && state_reg == IRRX_HOLD)
        else $error("input not ignored in hold");
    a_read_resume: assert property ((in_hold && run && rd_sft) |=> !hold_reg // [R14]
        && state_reg == IRRX_IDLE)
        else $error("shift read did not resume");
    a_stop_clears: assert property (!run |=> !hold_reg && bct_reg == 3'h0 // [R21]
        && sft_reg == 8'h00 && state_reg == IRRX_IDLE)
        else $error("stop did not clear receiver");
    a_byte_copy: assert property (byte_done |=> full_reg && sft_reg == 8'h00 // [R11]
        && rdt_reg == $past(shifted) && bct_reg == 3'h0)
        else $error("byte not moved to data register");
    a_lsb_first: assert property ((take_bit && !dir_msb && !byte_done) // [R1]
        |=> sft_reg[7] == $past(rx_bit))
        else $error("lsb-first bit not at top");
    a_edge_restart: assert property ((restart && run) |=> mm_cnt_reg == 6'h00 // [R23]
        ##1 mm_cnt_reg <= 6'h01)
        else $error("mismatch counter not restarted");
endmodule // irrx_receiver
`default_nettype wire

// ===== irrx_ir_src.sv
// source model of the demodulated remote signal, idle low between frames
// assumes the caller enters its task right after a core clock edge
`timescale 1ns/100ps
`default_nettype none
module irrx_ir_src (
    input  wire logic i_core_clk,   // core clock
    output var  logic o_ir          // demodulated level
);
    initial o_ir = 1'b0;   // idle level at time zero
    // hold one level for n core clocks
    task automatic level(input logic v, input int n);
        o_ir <= v;
        repeat (n) @(posedge i_core_clk);
    endtask
endmodule // irrx_ir_src
`default_nettype wire

// ===== irrx_receiver_tb.sv
// bench: register map, a format A frame, a format C msb-first frame
// assumes unit = 4 core clocks (period select 0, count select 0)
`timescale 1ns/100ps
`default_nettype none
`include "irrx_consts.svh"
module irrx_receiver_tb;
    import irrx_pkg::*;
    logic        clk = 1'b0, rst = 1'b1, ir, err;      // clock, reset, pin
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
    logic [19:0] paddr = 20'h00000;                     // byte address
    irrx_word_t  pwdata = 32'h00000000, prdata;         // apb data
    logic [7:0]  rd;                                    // last byte read
    int          errors = 0, checks_done = 0;           // verdict counters
    irrx_receiver irrx_receiver_inst (.i_core_clk(clk), .i_sys_rst(rst), .i_ir_rx(ir),
        .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
        .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr));
    irrx_ir_src irrx_ir_src_inst (.i_core_clk(clk), .o_ir(ir));
    initial forever #2 clk = ~clk;   // 250 MHz
    task automatic print_verdict;
        if (errors == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp)
        begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // one apb transfer, result taken at the ready edge, then one idle cycle
    task automatic apb(input logic w, input logic [17:0] idx, input logic [7:0] wd);
        int n;
        n = 0;
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= {idx, 2'b00};
        pwdata  <= {24'h000000, wd};
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1 && ++n < 20);
        rd  = prdata[7:0];
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
        if (n >= 20)
        begin
            errors++;
            print_verdict();
        end
    endtask
    // lead pulse, symbols of 12 or 20 units, then poll status for the end flag
    task automatic send(input int lead, input logic [15:0] b, input int n, input logic [7:0] st);
        int k;
        irrx_ir_src_inst.level(1'b1, lead);
        for (k = 0; k < n; k++)
        begin
            irrx_ir_src_inst.level(1'b0, b[k] ? 72 : 40);
            irrx_ir_src_inst.level(1'b1, 8);
        end
        irrx_ir_src_inst.level(1'b0, 1);
        k = 0;
        do apb(1'b0, `IRRX_IDX_STAT, 8'h00); while (rd[3] !== 1'b1 && ++k < 100);
        if (k >= 100)
        begin
            errors++;
            print_verdict();
        end
        chk("status", st, rd);
    endtask
    task automatic t_map;
        apb(1'b0, `IRRX_IDX_XHW, 8'h00);
        chk("xhw reset", 8'h40, rd);
        apb(1'b0, 18'h0FE32, 8'h00);
        chk("unmapped", 8'h01, {7'h00, err});
    endtask
    task automatic t_fmt_a;
        apb(1'b1, `IRRX_IDX_GPW, 8'h08);
        apb(1'b1, `IRRX_IDX_DT0W, 8'h08);
        apb(1'b1, `IRRX_IDX_DT1W, 8'h80);
        apb(1'b1, `IRRX_IDX_XHW, 8'h3A);
        apb(1'b0, `IRRX_IDX_XHW, 8'h00);
        chk("xhw", 8'h7A, rd);
        apb(1'b1, `IRRX_IDX_CTRL, 8'h01);     // format A, run
        send(48, 16'h01A5, 9, 8'h0B);
        apb(1'b0, `IRRX_IDX_RDT, 8'h00);
        chk("data", 8'hA5, rd);
        apb(1'b0, `IRRX_IDX_CTPR, 8'h00);
        chk("ctpr", 8'h09, rd);
        apb(1'b0, `IRRX_IDX_SFT, 8'h00);
        chk("shift", 8'h80, rd);
        apb(1'b0, `IRRX_IDX_CTPR, 8'h00);
        chk("hold", 8'h00, rd & 8'h08);
    endtask
    task automatic t_fmt_c;
        apb(1'b1, `IRRX_IDX_STAT, 8'h0F);
        apb(1'b1, `IRRX_IDX_XHW, 8'hBA);      // msb first
        apb(1'b1, `IRRX_IDX_CTRL, 8'h05);     // format C, run
        send(8, 16'h0006, 3, 8'h08);
        apb(1'b0, `IRRX_IDX_SFT, 8'h00);
        chk("shift msb", 8'h03, rd);
    endtask
    // format B: good guide then a short data pulse, then a frame stopped in hold
    task automatic t_fmt_b;
        apb(1'b1, `IRRX_IDX_STAT, 8'h0F);
        apb(1'b1, `IRRX_IDX_CTRL, 8'h03);     // format B, run
        irrx_ir_src_inst.level(1'b1, 8);
        irrx_ir_src_inst.level(1'b0, 40);
        irrx_ir_src_inst.level(1'b1, 8);
        irrx_ir_src_inst.level(1'b0, 8);
        irrx_ir_src_inst.level(1'b1, 8);
        irrx_ir_src_inst.level(1'b0, 1);
        apb(1'b0, `IRRX_IDX_STAT, 8'h00);
        chk("data error", 8'h05, rd);
        send(8, 16'h0006, 3, 8'h0D);
        apb(1'b0, `IRRX_IDX_CTPR, 8'h00);
        chk("ctpr b", 8'h0A, rd);
        apb(1'b1, `IRRX_IDX_CTRL, 8'h02);     // stop while held
        apb(1'b0, `IRRX_IDX_CTPR, 8'h00);
        chk("stopped", 8'h00, rd);
    endtask
    initial
    begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        t_map();
        t_fmt_a();
        t_fmt_c();
        t_fmt_b();
        print_verdict();
    end
endmodule // irrx_receiver_tb
`default_nettype wire
